// ### iop_pkg.sv
// Package of constants, codes and carrier types for the I/O ring port event counters
`default_nettype none
package iop_pkg;
    // ************************************************************
    // Widths, counts, limits and reset value
    // ************************************************************
    localparam int CTR_W = 48;
    localparam int NUM_CTRS = 2;
    localparam int INC_W = 6;
    localparam int OCC_W = 5;
    localparam int OUT_OCC_W = 6;
    localparam int SRC_W = 5;
    localparam logic [OCC_W-1:0] BULK_OCC_MAX = 5'h18;
    localparam logic [CTR_W-1:0] CTR_RESET = 48'h000000000000;
    // ************************************************************
    // Event codes
    // ************************************************************
    localparam logic [7:0] EV_PORT_CYCLE = 8'h00;
    localparam logic [7:0] EV_BULK_ALLOC = 8'h03;
    localparam logic [7:0] EV_BULK_OCC = 8'h09;
    localparam logic [7:0] EV_OUT_OCC = 8'h0D;
    localparam logic [7:0] EV_OUT_BYPASS = 8'h0E;
    localparam logic [7:0] EV_OUT_STD = 8'h0F;
    localparam logic [7:0] EV_TXN = 8'h16;
    localparam logic [7:0] EV_SNOOP = 8'h17;
    localparam logic [7:0] EV_ADDR_STALL = 8'h18;
    localparam logic [7:0] EV_BULK_STALL = 8'h19;
    // ************************************************************
    // Unit mask field positions
    // ************************************************************
    localparam int SNP_OUTCOME_LSB = 0;
    localparam int SNP_TYPE_LSB = 4;
    localparam int TXN_TYPE_LSB = 0;
    localparam int TXN_SOURCE_SELECT_BIT = 7;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SNP_MISS, SNP_HIT_INVALID, SNP_HIT_EXCL_SHARED, SNP_HIT_MODIFIED
    } iop_snoop_outcome_type;
    typedef enum logic [1:0] {
        SNP_TYPE_CODE, SNP_TYPE_DATA, SNP_TYPE_INVALIDATE
    } iop_snoop_kind_type;
    typedef enum logic [2:0] {
        TXN_READ, TXN_WRITE, TXN_READ_PREFETCH, TXN_WRITE_PREFETCH, TXN_ATOMIC, TXN_OTHER
    } iop_txn_kind_type;
    typedef struct packed {
        logic en;
        logic [7:0] ev_sel;
        logic [7:0] umask;
    } iop_ctl_type;
    typedef struct packed {
        logic bulk_ingress_std_alloc;
        logic [OCC_W-1:0] bulk_ingress_std_occupancy;
        logic snoop_valid;
        iop_snoop_outcome_type snoop_outcome;
        iop_snoop_kind_type snoop_kind;
        logic txn_valid;
        iop_txn_kind_type txn_kind;
        logic [SRC_W-1:0] txn_source;
        logic addr_egress_credit_stall;
        logic bulk_egress_credit_stall;
        logic outbound_req_bypass_class;
        logic outbound_req_std_class;
        logic [OUT_OCC_W-1:0] outbound_req_occupancy;
    } iop_events_type;
    typedef struct packed {
        logic [NUM_CTRS-1:0][CTR_W-1:0] count;
    } iop_state_type;
endpackage
`default_nettype wire

// ### iop_event_select.sv
// Event selection and qualification for one counter
`timescale 1ns/1ps
`default_nettype none
module iop_event_select (
    input wire iop_pkg::iop_ctl_type i_ctl,
    input wire iop_pkg::iop_events_type i_events,
    input wire logic [iop_pkg::SRC_W-1:0] i_source_filter,
    output logic [iop_pkg::INC_W-1:0] o_inc
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [iop_pkg::INC_W-1:0] one_if(input logic cond);
        one_if = cond ? 6'h01 : 6'h00;
    endfunction

    logic snoop_hit;
    logic txn_hit;
    logic [iop_pkg::OCC_W-1:0] bulk_occ;

    always_comb begin
        // Outcome bit and kind bit must both be set, else nothing counts
        // Kind code 3 is unused; without this guard it would read the source select bit
        snoop_hit = i_events.snoop_valid
            && (i_events.snoop_kind <= iop_pkg::SNP_TYPE_INVALIDATE)
            && i_ctl.umask[iop_pkg::SNP_OUTCOME_LSB + int'(i_events.snoop_outcome)]
            && i_ctl.umask[iop_pkg::SNP_TYPE_LSB + int'(i_events.snoop_kind)];
        // OR over enabled kinds, a retried write is a fresh presentation and counts again
        txn_hit = i_events.txn_valid
            && (i_events.txn_kind <= iop_pkg::TXN_OTHER)
            && i_ctl.umask[iop_pkg::TXN_TYPE_LSB + int'(i_events.txn_kind)];
        if (i_ctl.umask[iop_pkg::TXN_SOURCE_SELECT_BIT]) begin
            txn_hit = txn_hit && (i_events.txn_source == i_source_filter);
        end
        // Clamp guards against an out-of-range occupancy from the queue
        bulk_occ = (i_events.bulk_ingress_std_occupancy > iop_pkg::BULK_OCC_MAX)
            ? iop_pkg::BULK_OCC_MAX : i_events.bulk_ingress_std_occupancy;
        unique case (i_ctl.ev_sel)
            iop_pkg::EV_PORT_CYCLE: o_inc = 6'h01;
            iop_pkg::EV_BULK_ALLOC: o_inc = one_if(i_events.bulk_ingress_std_alloc);
            iop_pkg::EV_BULK_OCC: o_inc = {1'b0, bulk_occ};
            iop_pkg::EV_OUT_OCC: o_inc = i_events.outbound_req_occupancy;
            iop_pkg::EV_OUT_BYPASS: o_inc = one_if(i_events.outbound_req_bypass_class);
            iop_pkg::EV_OUT_STD: o_inc = one_if(i_events.outbound_req_std_class);
            iop_pkg::EV_TXN: o_inc = one_if(txn_hit);
            iop_pkg::EV_SNOOP: o_inc = one_if(snoop_hit);
            iop_pkg::EV_ADDR_STALL: o_inc = one_if(i_events.addr_egress_credit_stall);
            iop_pkg::EV_BULK_STALL: o_inc = one_if(i_events.bulk_egress_credit_stall);
            default: o_inc = 6'h00;
        endcase
    end
endmodule
`default_nettype wire

// ### iop_counters.sv
// Two event counters of the I/O ring port with their event selection
`timescale 1ns/1ps
`default_nettype none
module iop_counters (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire iop_pkg::iop_ctl_type [iop_pkg::NUM_CTRS-1:0] i_ctl,
    input wire logic [iop_pkg::SRC_W-1:0] i_source_filter,
    input wire iop_pkg::iop_events_type i_events,
    input wire logic [iop_pkg::NUM_CTRS-1:0] i_ctr_wr,
    input wire logic [iop_pkg::CTR_W-1:0] i_ctr_wdata,
    output logic [iop_pkg::NUM_CTRS-1:0][iop_pkg::CTR_W-1:0] o_count
);
    // ************************************************************
    // Event selection
    // ************************************************************
    logic [iop_pkg::NUM_CTRS-1:0][iop_pkg::INC_W-1:0] inc;

    // Only two counters are built; the port's events cannot land elsewhere
    for (genvar g = 0; g < iop_pkg::NUM_CTRS; g++) begin : g_sel
        iop_event_select u_sel (
            .i_ctl(i_ctl[g]),
            .i_events(i_events),
            .i_source_filter(i_source_filter),
            .o_inc(inc[g])
        );
    end

    // ************************************************************
    // Counter state
    // ************************************************************
    iop_pkg::iop_state_type state;
    iop_pkg::iop_state_type next_state;

    always_comb begin
        next_state = state;
        for (int k = 0; k < iop_pkg::NUM_CTRS; k++) begin
            // Software write wins over a same-cycle increment, so a preset is exact
            if (i_ctr_wr[k]) begin
                next_state.count[k] = i_ctr_wdata;
            end else if (i_ctl[k].en) begin
                next_state.count[k] = state.count[k] + iop_pkg::CTR_W'(inc[k]);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < iop_pkg::NUM_CTRS; k++) begin
                state.count[k] <= iop_pkg::CTR_RESET;
            end
        end else begin
            state <= next_state;
        end
    end

    assign o_count = state.count;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    logic [iop_pkg::INC_W-1:0] exp_occ;
    always_comb begin
        exp_occ = (i_events.bulk_ingress_std_occupancy > iop_pkg::BULK_OCC_MAX)
            ? 6'h18 : {1'b0, i_events.bulk_ingress_std_occupancy};
    end

    sequence s_write0;
        i_ctr_wr[0] ##1 !i_ctr_wr[0];
    endsequence

    sequence s_held0;
        (!i_ctl[0].en && !i_ctr_wr[0]) ##1 1'b1;
    endsequence

    a_write_readback: assert property (
        s_write0 |-> o_count[0] == $past(i_ctr_wdata, 1))
        else $error("counter 0 did not take the written value");

    a_cycle_tick: assert property (
        (i_ctl[0].en && i_ctl[0].ev_sel == 8'h00 && !i_ctr_wr[0])
        |=> o_count[0] == $past(o_count[0]) + 48'h000000000001)
        else $error("cycle event did not add one");

    a_bulk_alloc: assert property (
        i_ctl[0].ev_sel == 8'h03 |-> inc[0] == {5'h00, i_events.bulk_ingress_std_alloc})
        else $error("bulk allocation increment wrong");

    a_bulk_occupancy: assert property (
        i_ctl[0].ev_sel == 8'h09 |-> inc[0] == exp_occ && inc[0] <= 6'h18)
        else $error("bulk occupancy increment wrong");

    a_snoop_groups: assert property (
        i_ctl[0].ev_sel == 8'h17 && (i_ctl[0].umask[3:0] == 4'h0 || i_ctl[0].umask[6:4] == 3'h0)
        |-> inc[0] == 6'h00)
        else $error("snoop counted without both groups");

    a_txn_source: assert property (
        i_ctl[0].ev_sel == 8'h16 && i_ctl[0].umask[7] && i_events.txn_source != i_source_filter
        |-> inc[0] == 6'h00)
        else $error("transaction from other source counted");

    a_txn_match: assert property (
        i_ctl[0].ev_sel == 8'h16 && !i_ctl[0].umask[7] && i_events.txn_valid
        && i_ctl[0].umask[i_events.txn_kind] |-> inc[0] == 6'h01)
        else $error("matching transaction not counted");

    a_txn_retry: assert property (
        i_ctl[0].ev_sel == 8'h16 && !i_ctl[0].umask[7] && i_ctl[0].umask[1] && i_events.txn_valid
        && i_events.txn_kind == iop_pkg::TXN_WRITE |-> inc[0] == 6'h01)
        else $error("write presentation not counted");

    a_bulk_stall: assert property (
        i_ctl[0].ev_sel == 8'h19 |-> inc[0] == {5'h00, i_events.bulk_egress_credit_stall})
        else $error("bulk credit stall increment wrong");

    a_out_bypass: assert property (
        i_ctl[0].ev_sel == 8'h0E |-> inc[0] == {5'h00, i_events.outbound_req_bypass_class})
        else $error("bypass class request increment wrong");

    a_out_standard: assert property (
        i_ctl[0].ev_sel == 8'h0F |-> inc[0] == {5'h00, i_events.outbound_req_std_class})
        else $error("standard class request increment wrong");

    a_unknown_code: assert property (
        i_ctl[0].ev_sel == 8'h42 |-> inc[0] == 6'h00)
        else $error("undecoded event code counted");

    a_ctr1_tick: assert property (
        (i_ctl[1].en && i_ctl[1].ev_sel == 8'h00 && !i_ctr_wr[1])
        |=> o_count[1] == $past(o_count[1]) + 48'h000000000001)
        else $error("counter 1 cycle event did not add one");

    a_ctr1_write: assert property (
        i_ctr_wr[1] |=> o_count[1] == $past(i_ctr_wdata))
        else $error("counter 1 did not take the written value");

    a_stall_count: assert property (
        i_ctl[0].ev_sel == 8'h18 |-> inc[0] == {5'h00, i_events.addr_egress_credit_stall})
        else $error("address credit stall increment wrong");

    a_out_occupancy: assert property (
        i_ctl[0].ev_sel == 8'h0D && i_ctl[0].en && !i_ctr_wr[0]
        |=> o_count[0] == $past(o_count[0]) + 48'($past(i_events.outbound_req_occupancy)))
        else $error("outbound occupancy not accumulated");

    a_single_step: assert property (
        i_ctl[1].ev_sel != 8'h09 && i_ctl[1].ev_sel != 8'h0D |-> inc[1] <= 6'h01)
        else $error("non-occupancy event added more than one");

    a_disabled_hold: assert property (
        s_held0 |-> o_count[0] == $past(o_count[0]))
        else $error("disabled counter changed");
endmodule
`default_nettype wire

// ### iop_traffic_model.sv
// Model of the port traffic that feeds the counter event inputs
`timescale 1ns/1ps
`default_nettype none
module iop_traffic_model (
    input wire logic i_clk,
    output var iop_pkg::iop_events_type o_events
);
    // ************************************************************
    // Traffic bursts
    // ************************************************************
    // Every event line rests at zero between bursts, so a stale pulse never counts twice
    initial begin
        o_events = '0;
    end
    // One pattern held n cycles: a retried write is a fresh pulse on each cycle
    task automatic burst(input iop_pkg::iop_events_type e, input int n);
        o_events = e;
        repeat (n) @(posedge i_clk);
        #1;
        o_events = '0;
    endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the I/O ring port event counters
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    localparam logic [47:0] Z = iop_pkg::CTR_RESET;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    iop_pkg::iop_ctl_type [1:0] ctl = '0;
    logic [4:0] filter = 5'h00;
    logic [1:0] ctr_wr = 2'h0;
    logic [47:0] wdata = 48'h000000000000;
    iop_pkg::iop_events_type ev;
    logic [1:0][47:0] count;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    always #2.5 i_clk = ~i_clk;
    iop_traffic_model iop_traffic_model_i (.i_clk(i_clk), .o_events(ev));
    iop_counters iop_counters_i (.i_clk(i_clk), .i_rst(i_rst), .i_ctl(ctl), .i_source_filter(filter),
        .i_events(ev), .i_ctr_wr(ctr_wr), .i_ctr_wdata(wdata), .o_count(count));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Runs take a few hundred cycles; a hang is cut off well past that
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    // Preset both counters, then n cycles of one pattern; counter 1 counts port cycles meanwhile
    task automatic run(input logic [7:0] sel, input logic [7:0] um, input iop_pkg::iop_events_type e,
        input int n, input int inc, input logic [47:0] init);
        ctl[0] = '{en: 1'b1, ev_sel: sel, umask: um};
        ctl[1] = '{en: 1'b1, ev_sel: iop_pkg::EV_PORT_CYCLE, umask: 8'h00};
        ctr_wr = 2'h3;
        wdata = init;
        @(posedge i_clk);
        #1;
        ctr_wr = 2'h0;
        iop_traffic_model_i.burst(e, n);
        `CHK("count0", init + 48'(n * inc), count[0])
        `CHK("count1", init + 48'(n), count[1])
    endtask
    task automatic check_single();
        iop_pkg::iop_events_type e;
        logic [7:0] codes [5];
        codes = '{iop_pkg::EV_BULK_ALLOC, iop_pkg::EV_ADDR_STALL, iop_pkg::EV_BULK_STALL,
            iop_pkg::EV_OUT_BYPASS, iop_pkg::EV_OUT_STD};
        e = '0;
        run(iop_pkg::EV_PORT_CYCLE, 8'h00, e, 3, 1, 48'hFFFFFFFFFFFE);
        ctl[0] = '{en: 1'b0, ev_sel: iop_pkg::EV_PORT_CYCLE, umask: 8'h00};
        ctr_wr = 2'h1;
        wdata = 48'h000000000005;
        @(posedge i_clk);
        #1;
        ctr_wr = 2'h0;
        repeat (3) @(posedge i_clk);
        #1;
        `CHK("hold", 48'h000000000005, count[0])
        for (int i = 0; i < 5; i++) begin
            e = '0;
            {e.bulk_ingress_std_alloc, e.addr_egress_credit_stall, e.bulk_egress_credit_stall,
                e.outbound_req_bypass_class, e.outbound_req_std_class} = 5'h10 >> i;
            run(8'h42, 8'h00, e, 2, 0, Z);
            for (int j = 0; j < 5; j++) begin
                run(codes[j], 8'h00, e, 2, int'(i == j), Z);
            end
        end
    endtask
    task automatic check_levels();
        iop_pkg::iop_events_type e;
        e = '0;
        e.bulk_ingress_std_occupancy = 5'h18;
        e.outbound_req_occupancy = 6'h2A;
        run(iop_pkg::EV_BULK_OCC, 8'h00, e, 4, 24, Z);
        run(iop_pkg::EV_OUT_OCC, 8'h00, e, 3, 42, Z);
        e.bulk_ingress_std_occupancy = 5'h0D;
        run(iop_pkg::EV_BULK_OCC, 8'h00, e, 3, 13, Z);
    endtask
    task automatic check_snoop();
        iop_pkg::iop_events_type e;
        for (int o = 0; o < 4; o++) begin
            for (int k = 0; k < 3; k++) begin
                e = '0;
                e.snoop_valid = 1'b1;
                e.snoop_outcome = iop_pkg::iop_snoop_outcome_type'(o);
                e.snoop_kind = iop_pkg::iop_snoop_kind_type'(k);
                run(iop_pkg::EV_SNOOP, 8'((1 << o) | (16 << k)), e, 2, 1, Z);
                run(iop_pkg::EV_SNOOP, 8'(127 ^ (1 << o)), e, 2, 0, Z);
                run(iop_pkg::EV_SNOOP, 8'(127 ^ (16 << k)), e, 2, 0, Z);
            end
        end
        run(iop_pkg::EV_SNOOP, 8'h0F, e, 2, 0, Z);
    endtask
    task automatic check_txn();
        iop_pkg::iop_events_type e;
        for (int k = 0; k < 6; k++) begin
            e = '0;
            e.txn_valid = 1'b1;
            e.txn_kind = iop_pkg::iop_txn_kind_type'(k);
            e.txn_source = 5'h09;
            run(iop_pkg::EV_TXN, 8'(1 << k), e, 3, 1, Z);
            run(iop_pkg::EV_TXN, 8'(63 ^ (1 << k)), e, 2, 0, Z);
            run(iop_pkg::EV_TXN, 8'h3F, e, 2, 1, Z);
            filter = 5'h09;
            run(iop_pkg::EV_TXN, 8'(128 | (1 << k)), e, 2, 1, Z);
            filter = 5'h08;
            run(iop_pkg::EV_TXN, 8'(128 | (1 << k)), e, 2, 0, Z);
            run(iop_pkg::EV_TXN, 8'h80, e, 2, 0, Z);
        end
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        `CHK("reset", Z, count[0])
        check_single();
        check_levels();
        check_snoop();
        check_txn();
        i_rst = 1'b1;
        @(posedge i_clk);
        #1;
        `CHK("rerun", Z, count[1])
        end_of_test();
    end
endmodule
`default_nettype wire
